// file: hdl/isel_ep_evt.sv
// Purpose: Reduce the protocol engine events of one endpoint to one request pulse.
// Assumes: Event inputs are single-cycle pulses on the core clock.
// Notes:   Control endpoint adds SETUP and zero-length status events.
`timescale 1ns/1ns
module isel_ep_evt
    import isel_pkg::*;
#(
    parameter bit IS_CONTROL = 1'b0
) (
    // Events
    input  wire isel_ep_evt_type evt_in,
    // Request
    output logic                 req_out
);
    logic data_hit;

    assign data_hit = evt_in.data_rx & (evt_in.data_valid | evt_in.ack_rx_mode);

    always_comb begin
        req_out = data_hit | evt_in.nak_stall_sent;
        if (IS_CONTROL) begin
            req_out = req_out | (evt_in.setup_rx & evt_in.setup_accept) | evt_in.zero_len_sent;
        end else begin
            req_out = req_out | evt_in.in_ack_rx;
        end
    end
endmodule

// file: hdl/isel_top.sv
// Purpose: Interrupt sources, enables and pending latches toward the core.
// Assumes: Pins are asynchronous and are synchronised here; events are core-clock pulses.
// Notes:   Pending bits clear by acknowledge strobe or by writing ones to the ack address.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
module isel_top
    import isel_pkg::*;
#(
    parameter int PORT_W = 8
) (
    // Clock and reset
    input  wire logic                  mclk_in,
    input  wire logic                  rst_b_in,
    // Register port
    input  wire isel_bus_type          bus_in,
    output logic [7:0]                 rdata_out,
    // Pins
    input  wire logic [PORT_W-1:0]     port_a_pins_in,
    input  wire logic [PORT_W-1:0]     port_b_pins_in,
    input  wire logic                  usb_dp_in,
    input  wire logic                  usb_dm_in,
    input  wire logic                  ps2_data_pin_in,
    // Capture and serial peripheral events
    input  wire logic                  cap_a_evt_in,
    input  wire logic                  cap_b_evt_in,
    input  wire logic                  spi_byte_done_in,
    input  wire logic [7:0]            spi_rx_byte_in,
    // USB protocol engine events
    input  wire isel_ep_evt_type       ep0_evt_in,
    input  wire isel_ep_evt_type       ep1_evt_in,
    input  wire isel_ep_evt_type       ep2_evt_in,
    // Core acknowledge
    input  wire logic [NUM_SRC-1:0]    ack_in,
    // Outputs
    output logic [NUM_SRC-1:0]         irq_out,
    output logic                       irq_any_out,
    output logic                       transfer_complete_flag_out,
    output logic                       addr_clear_out
);
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]           src_en;
    logic [2:0]           ep_en;
    logic [PORT_W-1:0]    pa_en;
    logic [PORT_W-1:0]    pb_en;
    logic [PORT_W-1:0]    pa_edge;
    logic [PORT_W-1:0]    pb_edge;
    logic                 bus_reset_source_select;
    logic [7:0]           spi_data;
    logic [NUM_SRC-1:0]   pending;
    logic [NUM_SRC-1:0]   raw_req;
    logic [NUM_SRC-1:0]   src_enable;
    logic [NUM_SRC-1:0]   sw_clear;

    function automatic logic hit(input logic [7:0] a);
        hit = bus_in.wr && (bus_in.addr == a);
    endfunction

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            src_en                  <= RESET_BYTE;
            ep_en                   <= '0;
            pa_en                   <= '0;
            pb_en                   <= '0;
            pa_edge                 <= '0;
            pb_edge                 <= '0;
            bus_reset_source_select <= 1'b0;
        end else begin
            if (hit(ADDR_SRC_EN)) begin
                src_en <= bus_in.wdata;
            end
            if (hit(ADDR_EP_EN)) begin
                ep_en <= bus_in.wdata[2:0] & EP_EN_MASK;
            end
            if (hit(ADDR_PORTA_EN)) begin
                pa_en <= bus_in.wdata[PORT_W-1:0];
            end
            if (hit(ADDR_PORTB_EN)) begin
                pb_en <= bus_in.wdata[PORT_W-1:0];
            end
            if (hit(ADDR_PORTA_EDGE)) begin
                pa_edge <= bus_in.wdata[PORT_W-1:0];
            end
            if (hit(ADDR_PORTB_EDGE)) begin
                pb_edge <= bus_in.wdata[PORT_W-1:0];
            end
            if (hit(ADDR_BUS_MODE)) begin
                bus_reset_source_select <= bus_in.wdata[0];
            end
        end
    end

    // Reads; port enable and edge registers are write-only and read zero
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out <= RESET_BYTE;
        end else if (bus_in.rd) begin
            unique case (bus_in.addr)
                ADDR_SRC_EN:   rdata_out <= src_en;
                ADDR_EP_EN:    rdata_out <= {5'h00, ep_en};
                ADDR_PENDING:  rdata_out <= pending[7:0];
                ADDR_ACK:      rdata_out <= {6'h00, pending[NUM_SRC-1:8]};
                ADDR_BUS_MODE: rdata_out <= {7'h00, bus_reset_source_select};
                ADDR_SPI_DATA: rdata_out <= spi_data;
                default:       rdata_out <= RESET_BYTE;
            endcase
        end else begin
            rdata_out <= RESET_BYTE;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    localparam int SYN_W = 2 * PORT_W + 3;
    logic [SYN_W-1:0] sync1;
    logic [SYN_W-1:0] sync2;
    logic [PORT_W-1:0] pa_s;
    logic [PORT_W-1:0] pb_s;
    logic dp_s;
    logic dm_s;
    logic ps2_s;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {port_a_pins_in, port_b_pins_in, usb_dp_in, usb_dm_in, ps2_data_pin_in};
            sync2 <= sync1;
        end
    end
    assign {pa_s, pb_s, dp_s, dm_s, ps2_s} = sync2;

    // ****************************************
    // Free-running timer
    // ****************************************
    logic [$clog2(TICK_SHORT_CYC)-1:0] pre_cnt;
    logic [$clog2(LONG_PER_SHORT)-1:0] long_cnt;
    logic tick_short;
    logic tick_long;

    assign tick_short = (pre_cnt == ($clog2(TICK_SHORT_CYC))'(TICK_SHORT_CYC - 1));
    assign tick_long  = tick_short && (long_cnt == ($clog2(LONG_PER_SHORT))'(LONG_PER_SHORT - 1));

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pre_cnt  <= '0;
            long_cnt <= '0;
        end else begin
            pre_cnt <= tick_short ? '0 : pre_cnt + 1'b1;
            if (tick_short) begin
                long_cnt <= long_cnt + 1'b1;
            end
        end
    end

    // ****************************************
    // Bus reset / PS2 activity
    // ****************************************
    logic       cond_now;
    logic [1:0] cond_ticks;
    logic       cond_long;
    logic       cond_long_q;
    logic       bus_evt;

    assign cond_now = bus_reset_source_select ? ~ps2_s : (~dp_s & ~dm_s);
    // Qualified by the live condition so the address clear drops with the pin, not a cycle later
    assign cond_long = cond_now && (cond_ticks == 2'(COND_MIN_TICKS));

    // persistence counted in 128 us ticks: 128 to 256 us
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cond_ticks <= '0;
        end else if (!cond_now) begin
            cond_ticks <= '0;
        end else if (tick_short && !cond_long) begin
            cond_ticks <= cond_ticks + 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cond_long_q <= 1'b0;
        end else begin
            cond_long_q <= cond_long;
        end
    end

    // at end in USB mode, at detection in PS2 mode
    assign bus_evt = bus_reset_source_select ? (cond_long & ~cond_long_q) : (~cond_long & cond_long_q);
    assign addr_clear_out = cond_long;

    // ****************************************
    // Serial peripheral data
    // ****************************************
    // data and flag valid with request
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            spi_data                   <= RESET_BYTE;
            transfer_complete_flag_out <= 1'b0;
        end else if (spi_byte_done_in) begin
            spi_data                   <= spi_rx_byte_in;
            transfer_complete_flag_out <= 1'b1;
        end else if (bus_in.rd && bus_in.addr == ADDR_SPI_DATA) begin
            transfer_complete_flag_out <= 1'b0;
        end
    end

    // ****************************************
    // GPIO edges
    // ****************************************
    logic [2*PORT_W-1:0] pin_now;
    logic [2*PORT_W-1:0] pin_prev;
    logic [2*PORT_W-1:0] pin_pol;
    logic [2*PORT_W-1:0] pin_en;
    logic [2*PORT_W-1:0] pin_trig;
    logic                gpio_busy;
    logic                gpio_evt;

    assign pin_now = {pb_s, pa_s};
    assign pin_pol = {pb_edge, pa_edge};
    assign pin_en  = {pb_en, pa_en};

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_prev <= '0;
        end else begin
            pin_prev <= pin_now;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2 * PORT_W; gi++) begin : g_pin
            assign pin_trig[gi] = pin_en[gi] & (pin_pol[gi] ? (pin_now[gi] & ~pin_prev[gi])
                                                            : (~pin_now[gi] & pin_prev[gi]));
        end
    endgenerate

    // triggered pin blocks others while held at trigger level
    always_comb begin
        gpio_busy = 1'b0;
        for (int i = 0; i < 2 * PORT_W; i++) begin
            if (pin_en[i] && (pin_now[i] == pin_pol[i]) && (pin_prev[i] == pin_pol[i])) begin
                gpio_busy = 1'b1;
            end
        end
    end

    logic gpio_lock;
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gpio_lock <= 1'b0;
        end else if (|pin_trig && !gpio_lock) begin
            gpio_lock <= 1'b1;
        end else if (!gpio_busy) begin
            gpio_lock <= 1'b0;
        end
    end
    assign gpio_evt = |pin_trig & ~gpio_lock;

    // ****************************************
    // Endpoints
    // ****************************************
    logic ep0_req;
    logic ep1_req;
    logic ep2_req;

    isel_ep_evt #(.IS_CONTROL(1'b1)) u_ep0 (
        .evt_in  (ep0_evt_in),
        .req_out (ep0_req)
    );
    isel_ep_evt #(.IS_CONTROL(1'b0)) u_ep1 (
        .evt_in  (ep1_evt_in),
        .req_out (ep1_req)
    );
    isel_ep_evt #(.IS_CONTROL(1'b0)) u_ep2 (
        .evt_in  (ep2_evt_in),
        .req_out (ep2_req)
    );

    // ****************************************
    // Pending and gating
    // ****************************************
    always_comb begin
        raw_req            = '0;
        raw_req[SRC_BUS]   = bus_evt;
        raw_req[SRC_T128]  = tick_short;
        raw_req[SRC_T1024] = tick_long;
        raw_req[SRC_SPI]   = spi_byte_done_in;
        raw_req[SRC_CAPA]  = cap_a_evt_in;
        raw_req[SRC_CAPB]  = cap_b_evt_in;
        raw_req[SRC_GPIO]  = gpio_evt;
        raw_req[SRC_EP0]   = ep0_req;
        raw_req[SRC_EP1]   = ep1_req;
        raw_req[SRC_EP2]   = ep2_req;
    end

    assign src_enable = {ep_en, src_en[6:0]};
    assign sw_clear   = hit(ADDR_ACK) ? {bus_in.wdata[1:0], bus_in.wdata} : '0;

    // latch pending; set wins over clear
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pending <= '0;
        end else begin
            pending <= (pending & ~(ack_in | sw_clear)) | raw_req;
        end
    end

    assign irq_out     = pending & src_enable;
    assign irq_any_out = |irq_out;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_cond_start;
        $rose(cond_now);
    endsequence

    a_pend_set_wins: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        raw_req[SRC_SPI] |=> pending[SRC_SPI]) else $error("spi request lost");
    a_irq_gate_en: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        irq_out[SRC_T128] |-> src_en[SRC_T128]) else $error("ungated irq");
    a_short_period: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        tick_short |=> !tick_short [*8]) else $error("tick too soon");
    a_long_sub_short: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        tick_long |-> tick_short) else $error("long tick off grid");
    a_cond_min_time: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        s_cond_start |-> !cond_long [*8]) else $error("bus condition too early");
    a_addr_clear: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        cond_long |-> addr_clear_out && cond_now) else $error("address not cleared");
    a_usb_at_end: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (!bus_reset_source_select && bus_evt) |-> $past(cond_long) && !cond_long) else $error("usb irq timing");
    a_spi_data_ready: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        spi_byte_done_in |=> transfer_complete_flag_out && spi_data == $past(spi_rx_byte_in))
        else $error("spi data not ready");
    a_ep_reserved: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $past(bus_in.rd) && $past(bus_in.addr) == ADDR_EP_EN |-> rdata_out[7:3] == 5'h00)
        else $error("reserved bits set");
    a_gpio_lockout: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        gpio_lock && gpio_busy |-> !gpio_evt) else $error("second pin interrupt");
endmodule

// file: shared/isel_pkg.sv
// Purpose: Constants and carrier types for the interrupt source and enable logic.
// Assumes: 50 MHz core clock, plain register port with one-cycle read latency.
// Notes:   Pending bits latch while disabled; enables only gate the request lines.
package isel_pkg;
    localparam int          CLK_HZ            = 50_000_000;
    localparam int          TICK_SHORT_US     = 128;
    localparam int          TICK_LONG_US      = 1024;
    localparam int          TICK_SHORT_CYC    = CLK_HZ / 1_000_000 * TICK_SHORT_US;
    localparam int          LONG_PER_SHORT    = TICK_LONG_US / TICK_SHORT_US;
    localparam int          COND_MIN_TICKS    = 2;
    localparam logic [7:0]  ADDR_PORTA_EN     = 8'h04;
    localparam logic [7:0]  ADDR_PORTB_EN     = 8'h05;
    localparam logic [7:0]  ADDR_PORTA_EDGE   = 8'h06;
    localparam logic [7:0]  ADDR_PORTB_EDGE   = 8'h07;
    localparam logic [7:0]  ADDR_SRC_EN       = 8'h20;
    localparam logic [7:0]  ADDR_EP_EN        = 8'h21;
    localparam logic [7:0]  ADDR_PENDING      = 8'h22;
    localparam logic [7:0]  ADDR_ACK          = 8'h23;
    localparam logic [7:0]  ADDR_BUS_MODE     = 8'h24;
    localparam logic [7:0]  ADDR_SPI_DATA     = 8'h25;
    localparam logic [7:0]  RESET_BYTE        = 8'h00;
    localparam logic [2:0]  EP_EN_MASK        = 3'h7;
    localparam int          SRC_BUS           = 0;
    localparam int          SRC_T128          = 1;
    localparam int          SRC_T1024         = 2;
    localparam int          SRC_SPI           = 3;
    localparam int          SRC_CAPA          = 4;
    localparam int          SRC_CAPB          = 5;
    localparam int          SRC_GPIO          = 6;
    localparam int          NUM_SRC           = 10;
    localparam int          SRC_EP0           = 7;
    localparam int          SRC_EP1           = 8;
    localparam int          SRC_EP2           = 9;

    // Endpoint events from the USB protocol engine, one-cycle pulses
    typedef struct packed {
        logic data_rx;
        logic data_valid;
        logic ack_rx_mode;
        logic nak_stall_sent;
        logic in_ack_rx;
        logic setup_rx;
        logic setup_accept;
        logic zero_len_sent;
    } isel_ep_evt_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } isel_bus_type;
endpackage

// file: tb/isel_core_model.sv
// Purpose: Core acknowledge model that services raised requests.
// Assumes: Requests stand as levels until acknowledged.
// Notes:   dly_in picks prompt or slow service; one-cycle ack pulse.
`timescale 1ns/1ns
module isel_core_model
    import isel_pkg::*;
(
    // Clock and reset
    input  wire logic               mclk_in,
    input  wire logic               rst_b_in,
    // Requests and service time
    input  wire logic [NUM_SRC-1:0] irq_in,
    input  wire logic [7:0]         dly_in,
    // Acknowledge
    output logic      [NUM_SRC-1:0] ack_out
);
    // ********
    // Service
    // ********
    logic [7:0] wait_cnt;
    logic       busy;

    assign busy = (irq_in != '0) && (ack_out == '0);

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wait_cnt <= 8'h00;
            ack_out  <= '0;
        end else if (busy && wait_cnt == dly_in) begin
            wait_cnt <= 8'h00;
            ack_out  <= irq_in;
        end else begin
            wait_cnt <= busy ? wait_cnt + 8'h01 : 8'h00;
            ack_out  <= '0;
        end
    end
endmodule

// file: tb/tb.sv
// Purpose: Self-checking bench for the interrupt source and enable logic.
// Assumes: Register port with one-cycle read latency, core model acks.
// Notes:   Timer scenario runs right after the register scenario since its slot is counted from reset.
`timescale 1ns/1ns
module tb
    import isel_pkg::*;
;
    // ********
    // Harness
    // ********
    logic               mclk_in  = 1'b0;
    logic               rst_b_in = 1'b0;
    isel_bus_type       bus      = '0;
    logic [7:0]         rdata;
    logic [7:0]         pa       = 8'h00;
    logic [7:0]         pb       = 8'hFF;
    logic [7:0]         rx       = 8'h00;
    logic               dp       = 1'b1;
    logic               dm       = 1'b0;
    logic               ps2      = 1'b1;
    logic               cap_a    = 1'b0;
    logic               cap_b    = 1'b0;
    logic               spi      = 1'b0;
    isel_ep_evt_type    ep [3]   = '{default: '0};
    logic [NUM_SRC-1:0] ack;
    logic [NUM_SRC-1:0] irq;
    logic               irq_any;
    logic               tcf;
    logic               aclr;
    logic [7:0]         dly      = 8'h02;
    int                 bad_count = 0;
    int                 tests_run = 0;
    int                 cyc       = 0;
    int                 rel_cyc   = 0;

    always #10 mclk_in = ~mclk_in;
    always @(posedge mclk_in) cyc++;

    isel_top #(.PORT_W(8)) i_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .bus_in(bus), .rdata_out(rdata),
        .port_a_pins_in(pa), .port_b_pins_in(pb), .usb_dp_in(dp), .usb_dm_in(dm), .ps2_data_pin_in(ps2),
        .cap_a_evt_in(cap_a), .cap_b_evt_in(cap_b), .spi_byte_done_in(spi), .spi_rx_byte_in(rx),
        .ep0_evt_in(ep[0]), .ep1_evt_in(ep[1]), .ep2_evt_in(ep[2]), .ack_in(ack), .irq_out(irq),
        .irq_any_out(irq_any), .transfer_complete_flag_out(tcf), .addr_clear_out(aclr));

    isel_core_model i_core (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .irq_in(irq), .dly_in(dly), .ack_out(ack));

    // ********
    // Helpers
    // ********
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in);
        bus.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_in);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Bounded wait for one request line to reach a level
    task automatic await(input int idx, input logic lvl, input int lim);
        int n;
        n = 0;
        while (irq[idx] !== lvl) begin
            @(posedge mclk_in);
            #1 n++;
            if (n > lim) begin
                $display("unexpected wait on request %0d", idx);
                bad_count++;
                end_of_test();
            end
        end
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_regs();
        logic [7:0] d;
        logic [7:0] adr [5] = '{ADDR_SRC_EN, ADDR_EP_EN, ADDR_PORTA_EN, ADDR_PORTB_EDGE, 8'h3F};
        foreach (adr[i]) begin
            rd(adr[i], d);
            chk("reset or write-only read", 16'(d), 16'h0000);
        end
        wr(ADDR_EP_EN, 8'hFF);
        rd(ADDR_EP_EN, d);
        chk("endpoint enable", 16'(d), 16'h0007);
    endtask

    task automatic t_timers();
        int t0;
        wr(ADDR_SRC_EN, 8'h06);
        await(SRC_T128, 1'b1, TICK_SHORT_CYC + 100);
        t0 = cyc;
        await(SRC_T128, 1'b0, 40);
        await(SRC_T128, 1'b1, TICK_SHORT_CYC + 100);
        chk("short period", 16'(cyc - t0), 16'(TICK_SHORT_CYC));
        await(SRC_T1024, 1'b1, 52000);
        chk("long slot", 16'((cyc - rel_cyc) / TICK_SHORT_CYC), 16'(LONG_PER_SHORT));
        wr(ADDR_SRC_EN, 8'h00);
        repeat (TICK_SHORT_CYC + 100) @(posedge mclk_in);
        #1 chk("timers gated", 16'(irq[2:1]), 16'h0000);
        chk("no request", 16'(irq_any), 16'h0000);
    endtask

    task automatic t_spi();
        logic [7:0] d;
        wr(ADDR_SRC_EN, 8'h08);
        rx <= 8'hA5;
        spi <= 1'b1;
        @(posedge mclk_in);
        spi <= 1'b0;
        #1 chk("spi request", 16'(irq[SRC_SPI]), 16'h0001);
        chk("any request", 16'(irq_any), 16'h0001);
        chk("transfer complete", 16'(tcf), 16'h0001);
        rd(ADDR_SPI_DATA, d);
        chk("spi byte", 16'(d), 16'h00A5);
        await(SRC_SPI, 1'b0, 40);
    endtask

    task automatic t_cap();
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_SRC_EN, 8'h00);
            {cap_b, cap_a} <= 2'b01 << i;
            @(posedge mclk_in);
            {cap_b, cap_a} <= 2'b00;
            #1 chk("capture gated", 16'(irq[SRC_CAPA+i]), 16'h0000);
            wr(ADDR_SRC_EN, 8'h10 << i);
            chk("capture pending", 16'(irq[SRC_CAPA+i]), 16'h0001);
            await(SRC_CAPA + i, 1'b0, 40);
        end
    endtask

    task automatic t_swclr();
        logic [7:0] d;
        wr(ADDR_SRC_EN, 8'h00);
        cap_a <= 1'b1;
        @(posedge mclk_in);
        cap_a <= 1'b0;
        rd(ADDR_PENDING, d);
        chk("pending latched", 16'(d[SRC_CAPA]), 16'h0001);
        wr(ADDR_ACK, 8'h10);
        rd(ADDR_PENDING, d);
        chk("pending cleared", 16'(d[SRC_CAPA]), 16'h0000);
        wr(ADDR_BUS_MODE, 8'h01);
        rd(ADDR_BUS_MODE, d);
        chk("source select", 16'(d), 16'h0001);
        wr(ADDR_BUS_MODE, 8'h00);
    endtask

    task automatic t_ep();
        logic [7:0] kv [8] = '{8'hC0, 8'hA0, 8'h10, 8'h08, 8'h06, 8'h01, 8'h80, 8'h04};
        logic [2:0] km [8] = '{3'h7, 3'h7, 3'h7, 3'h6, 3'h1, 3'h1, 3'h0, 3'h0};
        dly <= 8'h1E;
        for (int e = 0; e < 3; e++) begin
            for (int k = 0; k < 8; k++) begin
                @(posedge mclk_in);
                ep[e] <= isel_ep_evt_type'(kv[k]);
                @(posedge mclk_in);
                ep[e] <= '0;
                #1 chk("endpoint request", 16'(irq[SRC_EP0+e]), 16'(km[k][e]));
                await(SRC_EP0 + e, 1'b0, 60);
            end
        end
        dly <= 8'h02;
    endtask

    task automatic t_gpio();
        wr(ADDR_SRC_EN, 8'h40);
        wr(ADDR_PORTA_EN, 8'h03);
        wr(ADDR_PORTA_EDGE, 8'h03);
        pa <= 8'h01;
        await(SRC_GPIO, 1'b1, 8);
        await(SRC_GPIO, 1'b0, 40);
        pa <= 8'h03;
        repeat (8) @(posedge mclk_in);
        #1 chk("pin lockout", 16'(irq[SRC_GPIO]), 16'h0000);
        pa <= 8'h00;
        wr(ADDR_PORTB_EN, 8'h80);
        wr(ADDR_PORTB_EDGE, 8'h00);
        pb <= 8'hFE;
        repeat (8) @(posedge mclk_in);
        #1 chk("pin disabled", 16'(irq[SRC_GPIO]), 16'h0000);
        pb <= 8'h7E;
        await(SRC_GPIO, 1'b1, 8);
        await(SRC_GPIO, 1'b0, 40);
    endtask

    task automatic t_bus();
        int t0;
        wr(ADDR_SRC_EN, 8'h01);
        wr(ADDR_BUS_MODE, 8'h01);
        ps2 <= 1'b0;
        t0 = cyc;
        await(SRC_BUS, 1'b1, 2 * TICK_SHORT_CYC + 20);
        chk("ps2 not early", 16'(cyc - t0 >= TICK_SHORT_CYC), 16'h0001);
        chk("address clear", 16'(aclr), 16'h0001);
        ps2 <= 1'b1;
        await(SRC_BUS, 1'b0, 40);
        wr(ADDR_BUS_MODE, 8'h00);
        {dp, dm} <= 2'b00;
        repeat (2 * TICK_SHORT_CYC + 50) @(posedge mclk_in);
        #1 chk("reset held", 16'(irq[SRC_BUS]), 16'h0000);
        chk("address clear", 16'(aclr), 16'h0001);
        dp <= 1'b1;
        await(SRC_BUS, 1'b1, TICK_SHORT_CYC + 20);
    endtask

    initial begin
        repeat (8) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        #1 rel_cyc = cyc;
        t_regs();
        t_timers();
        t_spi();
        t_cap();
        t_swclr();
        t_ep();
        t_gpio();
        t_bus();
        end_of_test();
    end
endmodule
